/* hdl/mpb_pkg.sv */
// Shared constants and types for the packet buffer host port.
package mpb_pkg;
   localparam int PAGE_WORDS = 1024;
   localparam int PAGES = 4;
   // Register indices; byte address is four times the index.
   localparam logic [3:0] R_TCR = 4'h0, R_HST = 4'h2, R_RCR = 4'h4, R_MIR = 4'h8;
   localparam logic [3:0] R_GCTL = 4'hC, R_PHYC = 4'h2, R_BANK = 4'hE;
   localparam logic [3:0] R_CMD = 4'h0, R_PNR = 4'h2, R_ARR = 4'h3, R_QUE = 4'h4;
   localparam logic [3:0] R_PTR = 4'h6, R_DATA = 4'h8, R_INT = 4'hC;
   localparam logic [1:0] B_CFG = 2'h0, B_CTL = 2'h1, B_BUF = 2'h2, B_PHY = 2'h3;
   // Field positions.
   localparam int TCR_TXEN = 0, TCR_SUPPRESS_CHECKSUM_APPEND = 8, TCR_FDX = 11, TCR_LOOP = 13;
   localparam int RCR_RECEIVER_ENABLE = 8, GC_AUTOREL = 11, GC_BAD = 14, PHY_PHY_INTERNAL_LOOPBACK = 14;
   localparam int PTR_INC = 14, PTR_RCV = 15, INT_RX = 0, INT_TX = 1, INT_AL = 3;
   localparam int CMD_BUSY = 0, CMD_LSB = 5, RXS_ERR = 15, ARR_FAIL = 7;
   // Word positions inside a packet page.
   localparam int W_STAT = 0, W_CNT = 1, W_FIRST = 2;
   // Reset values.
   localparam logic [15:0] REG_RST = 16'h0000;
   localparam logic [3:0] FREE_RST = 4'hF;
   localparam logic [7:0] ARR_RST = 8'h80, MEM_SIZE = 8'h04;
   typedef enum logic [2:0] {
      MC_NOP = 3'b000, MC_ALLOC = 3'b001, MC_RESET = 3'b010, MC_RXDROP = 3'b011,
      MC_RXREL = 3'b100, MC_REL = 3'b101, MC_ENQ = 3'b110, MC_TXRST = 3'b111
   } mpb_cmd_t;
   typedef enum logic [1:0] {
      T_IDLE = 2'b00, T_SEND = 2'b01, T_WAIT = 2'b10, T_STAT = 2'b11
   } mpb_tx_t;
   typedef enum logic [2:0] {
      R_IDLE = 3'b000, R_DAT = 3'b001, R_DROP = 3'b010, R_STA = 3'b011, R_CNT = 3'b100
   } mpb_rx_t;
endpackage

/* hdl/mpb_buffer_host.sv */
// Packet buffer, memory manager and banked register window of the MAC.
////////////////////////////////////////////////////////////////////////////////
//
// The Wishbone interface to the registers was left to the implementer.
module mpb_buffer_host #(
   parameter int PAGE_WORDS = mpb_pkg::PAGE_WORDS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic tx_valid_o,
   output logic [15:0] tx_data_o,
   output logic tx_last_o,
   input wire logic tx_ready_i,
   output logic tx_crc_o,
   input wire logic tx_done_i,
   input wire logic [15:0] tx_status_i,
   input wire logic rx_valid_i,
   input wire logic [15:0] rx_data_i,
   input wire logic rx_last_i,
   input wire logic rx_err_i,
   output logic full_duplex_o,
   output logic phy_loopback_o
);
   import mpb_pkg::*;
   localparam int AW = $clog2(PAGE_WORDS);
   localparam int MW = AW + 2;

   // The page index arithmetic needs a power of two of reasonable size.
   if (PAGE_WORDS < 16 || (PAGE_WORDS & (PAGE_WORDS - 1)) != 0) begin : g_chk
      $error("PAGE_WORDS must be a power of two of at least 16");
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [1:0] first_free(input logic [3:0] m);
      first_free = 2'd0;
      for (int i = 3; i >= 0; i--) begin
         if (m[i]) first_free = 2'(i);
      end
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
                                         input logic [1:0] s);
      return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
   endfunction

   logic [15:0] mem_r [0:4*PAGE_WORDS-1];
   logic [1:0] bank_r, pnr_r, tpg_r, rpg_r, txh_r, rxh_r, rx_new, apg;
   logic [1:0] txq_r [0:3];
   logic [1:0] rxq_r [0:3];
   logic [2:0] txn_r, rxn_r;
   logic [15:0] tcr_r, rcr_r, gctl_r, phyc_r, ptr_r, hst_r, rdata, tdat_r, s_data, rx_wd;
   logic [7:0] arr_r;
   logic [3:0] idx, free_r, free_nxt, fa, rel_m;
   logic [AW-1:0] twp_r, tend_r, wp_r, hw, hcw;
   logic [MW-1:0] haddr, rx_a;
   logic [31:0] dat_r;
   logic ack_r, req, take, wr, hit_data, mem_busy, cmd_go, alloc_fire, busy_r;
   logic alloc_pend_r, alloc_int_r, tx_int_r, tv_r, err_r, lb, fdx, tx_fire, tx_pop;
   logic s_valid, s_last, s_err, rx_ok, rx_take, rx_we, st_we, rx_bad, rx_push;
   logic auto_rel, enq, rx_pop;
   mpb_cmd_t cmd;
   mpb_tx_t tx_st;
   mpb_rx_t rx_st;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode; a data write waits while the link side owns the write port.
   assign idx = wb_adr_i[5:2];
   assign req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign hit_data = (bank_r == B_BUF) && (idx == R_DATA);
   assign mem_busy = rx_we | (tx_st == T_STAT);
   assign take = req & ~(hit_data & wb_we_i & mem_busy);
   assign wr = take & wb_we_i;
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign cmd = mpb_cmd_t'(wb_dat_i[CMD_LSB+2:CMD_LSB]);
   assign cmd_go = wr && bank_r == B_BUF && idx == R_CMD && wb_sel_i[0] && !busy_r;
   assign hw = ptr_r[AW:1];
   assign haddr = {ptr_r[PTR_RCV] ? rxq_r[rxh_r] : pnr_r, hw};

   // Read mux; unmapped offsets read as zero.
   always_comb begin
      rdata = 16'h0000;
      if (idx == R_BANK) begin
         rdata = {14'h0000, bank_r};
      end else begin
         case ({bank_r, idx})
            {B_CFG, R_TCR}: rdata = tcr_r;
            {B_CFG, R_HST}: rdata = hst_r;
            {B_CFG, R_RCR}: rdata = rcr_r;
            {B_CFG, R_MIR}: rdata = {5'h00, 3'($countones(free_r)), MEM_SIZE};
            {B_CTL, R_GCTL}: rdata = gctl_r;
            {B_BUF, R_CMD}: rdata = {15'h0000, busy_r};
            {B_BUF, R_PNR}: rdata = {14'h0000, pnr_r};
            {B_BUF, R_ARR}: rdata = {8'h00, arr_r};
            {B_BUF, R_QUE}: rdata = {rxn_r == 3'd0, 5'h00, rxq_r[rxh_r],
                                     txn_r == 3'd0, 5'h00, txq_r[txh_r]};
            {B_BUF, R_PTR}: rdata = ptr_r;
            {B_BUF, R_DATA}: rdata = mem_r[haddr];
            {B_BUF, R_INT}: rdata = {12'h000, alloc_int_r, 1'b0, tx_int_r, rxn_r != 3'd0};
            {B_PHY, R_PHYC}: rdata = phyc_r;
            default: rdata = 16'h0000;
         endcase
      end
   end

   // Acknowledge one cycle after a request is taken.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else begin
         ack_r <= take;
         if (take && !wb_we_i) dat_r <= {16'h0000, rdata};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software control registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bank_r <= 2'd0;
         tcr_r <= REG_RST;
         rcr_r <= REG_RST;
         gctl_r <= REG_RST;
         phyc_r <= REG_RST;
         pnr_r <= 2'd0;
      end else if (wr) begin
         if (idx == R_BANK && wb_sel_i[0]) bank_r <= wb_dat_i[1:0];
         case ({bank_r, idx})
            {B_CFG, R_TCR}: tcr_r <= merge(tcr_r, wb_dat_i[15:0], wb_sel_i[1:0]);
            {B_CFG, R_RCR}: rcr_r <= merge(rcr_r, wb_dat_i[15:0], wb_sel_i[1:0]);
            {B_CTL, R_GCTL}: gctl_r <= merge(gctl_r, wb_dat_i[15:0], wb_sel_i[1:0]);
            {B_PHY, R_PHYC}: phyc_r <= merge(phyc_r, wb_dat_i[15:0], wb_sel_i[1:0]);
            {B_BUF, R_PNR}: if (wb_sel_i[0]) pnr_r <= wb_dat_i[1:0];
            default: pnr_r <= pnr_r;
         endcase
      end
   end

   // Pointer; each data access steps it by one word when auto-advance is set.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ptr_r <= REG_RST;
      end else if (wr && bank_r == B_BUF && idx == R_PTR) begin
         ptr_r <= merge(ptr_r, wb_dat_i[15:0], wb_sel_i[1:0]);
      end else if (take && hit_data && ptr_r[PTR_INC]) begin
         ptr_r[AW:0] <= ptr_r[AW:0] + (AW+1)'(2);
      end
   end

   // Single write port: receive words first, then transmit status, then host.
   always_ff @(posedge clk_i) begin
      if (rx_we) begin
         mem_r[rx_a] <= rx_wd;
      end else if (tx_st == T_STAT) begin
         mem_r[{tpg_r, AW'(W_STAT)}] <= hst_r;
      end else if (wr && hit_data) begin
         mem_r[haddr] <= merge(mem_r[haddr], wb_dat_i[15:0], wb_sel_i[1:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Page bookkeeping; receive takes a page ahead of a pending allocation.
   assign rx_new = first_free(free_r);
   always_comb begin
      rel_m = 4'h0;
      if (cmd_go && cmd == MC_REL) rel_m[pnr_r] = 1'b1;
      if (cmd_go && cmd == MC_RXREL && rxn_r != 3'd0) rel_m[rxq_r[rxh_r]] = 1'b1;
      if (auto_rel) rel_m[tpg_r] = 1'b1;
      if (rx_bad) rel_m[rpg_r] = 1'b1;
      fa = free_r & ~(rx_take ? 4'(4'b0001 << rx_new) : 4'h0);
      apg = first_free(fa);
      alloc_fire = alloc_pend_r && fa != 4'h0;
      free_nxt = (fa & ~(alloc_fire ? 4'(4'b0001 << apg) : 4'h0)) | rel_m;
      if (cmd_go && cmd == MC_RESET) free_nxt = FREE_RST;
   end

   // Allocation, busy indication and allocation result.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         free_r <= FREE_RST;
         alloc_pend_r <= 1'b0;
         alloc_int_r <= 1'b0;
         arr_r <= ARR_RST;
         busy_r <= 1'b0;
      end else begin
         free_r <= free_nxt;
         busy_r <= cmd_go && (cmd == MC_REL || cmd == MC_RXREL);
         if (cmd_go && cmd == MC_RESET) begin
            alloc_pend_r <= 1'b0;
            alloc_int_r <= 1'b0;
         end else if (alloc_fire) begin
            // A page already taken is reported even when a new request lands with it.
            alloc_pend_r <= cmd_go && cmd == MC_ALLOC;
            alloc_int_r <= 1'b1;
            arr_r <= {6'h00, apg};
         end else if (cmd_go && cmd == MC_ALLOC) begin
            alloc_pend_r <= 1'b1;
            alloc_int_r <= 1'b0;
            arr_r[ARR_FAIL] <= 1'b1;
         end
      end
   end

   // Transmit and receive queues of packet numbers.
   assign enq = cmd_go && cmd == MC_ENQ && txn_r != 3'd4;
   assign rx_pop = cmd_go && (cmd == MC_RXREL || cmd == MC_RXDROP) && rxn_r != 3'd0;
   always_ff @(posedge clk_i) begin
      if (rst_i || (cmd_go && cmd == MC_RESET)) begin
         txn_r <= 3'd0;
         rxn_r <= 3'd0;
         txh_r <= 2'd0;
         rxh_r <= 2'd0;
         txq_r <= '{default: 2'd0};
         rxq_r <= '{default: 2'd0};
      end else begin
         if (enq) txq_r[2'(txh_r + txn_r[1:0])] <= pnr_r;
         if (rx_push) rxq_r[2'(rxh_r + rxn_r[1:0])] <= rpg_r;
         if (tx_pop) txh_r <= txh_r + 2'd1;
         if (rx_pop) rxh_r <= rxh_r + 2'd1;
         if (cmd_go && cmd == MC_TXRST) txn_r <= 3'd0;
         else txn_r <= 3'(txn_r + {2'b00, enq} - {2'b00, tx_pop});
         rxn_r <= 3'(rxn_r + {2'b00, rx_push} - {2'b00, rx_pop});
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit engine; the last word index comes from the stored byte count.
   assign lb = tcr_r[TCR_LOOP];
   assign fdx = tcr_r[TCR_FDX];
   assign hcw = mem_r[{txq_r[txh_r], AW'(W_CNT)}][AW:1];
   assign tx_fire = tv_r & (lb | tx_ready_i);
   assign tx_pop = tx_st == T_IDLE && tcr_r[TCR_TXEN] && txn_r != 3'd0
                   && (fdx || lb || rx_st == R_IDLE);
   assign st_we = tx_st == T_STAT && !rx_we;
   assign auto_rel = st_we && gctl_r[GC_AUTOREL];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_st <= T_IDLE;
         tv_r <= 1'b0;
         tpg_r <= 2'd0;
         twp_r <= '0;
         tend_r <= '0;
         tdat_r <= 16'h0000;
         hst_r <= REG_RST;
      end else begin
         case (tx_st)
            T_IDLE: if (tx_pop) begin
               tpg_r <= txq_r[txh_r];
               twp_r <= AW'(W_FIRST);
               tend_r <= (hcw > AW'(3)) ? hcw - AW'(1) : AW'(W_FIRST);
               tdat_r <= mem_r[{txq_r[txh_r], AW'(W_FIRST)}];
               tv_r <= 1'b1;
               tx_st <= T_SEND;
            end
            T_SEND: if (tx_fire) begin
               if (twp_r == tend_r) begin
                  tv_r <= 1'b0;
                  tx_st <= T_WAIT;
               end else begin
                  twp_r <= twp_r + AW'(1);
                  tdat_r <= mem_r[{tpg_r, twp_r + AW'(1)}];
               end
            end
            T_WAIT: if (lb || tx_done_i) begin
               hst_r <= lb ? REG_RST : tx_status_i;
               tx_st <= T_STAT;
            end
            T_STAT: if (st_we) tx_st <= T_IDLE;
            default: tx_st <= T_IDLE;
         endcase
      end
   end

   // Transmit flag; a completion in the clearing cycle wins.
   always_ff @(posedge clk_i) begin
      if (rst_i) tx_int_r <= 1'b0;
      else if (st_we) tx_int_r <= 1'b1;
      else if (wr && bank_r == B_BUF && idx == R_INT && wb_sel_i[0] && wb_dat_i[INT_TX])
         tx_int_r <= 1'b0;
   end

   // Loopback hides the frame from the wire and feeds the receive path.
   assign tx_valid_o = tv_r & ~lb;
   assign tx_last_o = tv_r & ~lb & (twp_r == tend_r);
   assign tx_data_o = tdat_r;
   assign tx_crc_o = ~tcr_r[TCR_SUPPRESS_CHECKSUM_APPEND];
   assign full_duplex_o = fdx;
   assign phy_loopback_o = phyc_r[PHY_PHY_INTERNAL_LOOPBACK];

   ////////////////////////////////////////////////////////////////////////////
   // Receive engine; frames land from word 2, header words are filled at end.
   assign s_valid = lb ? tx_fire : rx_valid_i;
   assign s_data = lb ? tdat_r : rx_data_i;
   assign s_last = lb ? (twp_r == tend_r) : rx_last_i;
   assign s_err = ~lb & rx_err_i;
   assign rx_ok = rcr_r[RCR_RECEIVER_ENABLE] && free_r != 4'h0
                  && (fdx || lb || tx_st == T_IDLE);
   assign rx_take = rx_st == R_IDLE && s_valid && rx_ok;
   assign rx_bad = rx_st == R_CNT && err_r && !gctl_r[GC_BAD];
   assign rx_push = rx_st == R_CNT && !rx_bad;
   always_comb begin
      rx_we = 1'b0;
      rx_a = {rpg_r, wp_r};
      rx_wd = s_data;
      case (rx_st)
         R_IDLE: begin
            rx_we = rx_take;
            rx_a = {rx_new, AW'(W_FIRST)};
         end
         R_DAT: rx_we = s_valid;
         R_STA: begin
            rx_we = 1'b1;
            rx_a = {rpg_r, AW'(W_STAT)};
            rx_wd = {err_r, 15'h0000};
         end
         R_CNT: begin
            rx_we = 1'b1;
            rx_a = {rpg_r, AW'(W_CNT)};
            rx_wd = 16'({wp_r, 1'b0});
         end
         default: rx_we = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_st <= R_IDLE;
         rpg_r <= 2'd0;
         wp_r <= '0;
         err_r <= 1'b0;
      end else begin
         case (rx_st)
            R_IDLE: if (s_valid) begin
               rpg_r <= rx_new;
               wp_r <= AW'(W_FIRST + 1);
               err_r <= s_err;
               if (!rx_ok) rx_st <= s_last ? R_IDLE : R_DROP;
               else rx_st <= s_last ? R_STA : R_DAT;
            end
            R_DAT: if (s_valid) begin
               if (wp_r != '1) wp_r <= wp_r + AW'(1);
               err_r <= err_r | s_err;
               if (s_last) rx_st <= R_STA;
            end
            R_DROP: if (s_valid && s_last) rx_st <= R_IDLE;
            R_STA: rx_st <= R_CNT;
            R_CNT: rx_st <= R_IDLE;
            default: rx_st <= R_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_rel;
      cmd_go && (cmd == MC_REL || cmd == MC_RXREL);
   endsequence
   sequence s_txend;
      tx_st == T_WAIT && (lb || tx_done_i) ##1 tx_st == T_STAT;
   endsequence
   bank_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == R_BANK && wb_sel_i[0] |=> bank_r == $past(wb_dat_i[1:0]))
      else $error("bank select not stored");
   alloc_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
      alloc_fire |=> alloc_int_r && arr_r[1:0] == $past(apg) && !arr_r[ARR_FAIL])
      else $error("allocation not reported");
   free_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
      alloc_fire && !rx_take && rel_m == 4'h0 && !(cmd_go && cmd == MC_RESET)
      |=> $countones(free_r) + 1 == $countones($past(free_r)))
      else $error("free count not decremented");
   busy_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_rel |=> busy_r ##1 !busy_r)
      else $error("busy bit not shown for release");
   tx_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_st == T_IDLE && !tcr_r[TCR_TXEN] |=> tx_st == T_IDLE)
      else $error("transmit started while disabled");
   tx_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_txend ##0 !rx_we |=> tx_int_r && tx_st == T_IDLE)
      else $error("transmit flag not set");
   rx_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_st == R_IDLE && !rcr_r[RCR_RECEIVER_ENABLE] |=> rx_st != R_DAT && rx_st != R_STA)
      else $error("frame accepted while receiver off");
   rx_queue_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_push && !rx_pop |=> rxn_r == $past(rxn_r) + 3'd1)
      else $error("received packet not queued");
   loop_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
      lb && tv_r && rx_st == R_DAT |-> !tx_valid_o && rx_we && rx_wd == tdat_r)
      else $error("loopback word not fed to the receive path");
endmodule

/* verification/mpb_handler_model.sv */
// Stand-in for the protocol handler on the far side of the buffer's link ports.
module mpb_handler_model (
   input wire logic clk_i,
   input wire logic tx_valid_i,
   input wire logic [15:0] tx_data_i,
   input wire logic tx_last_i,
   output logic tx_ready_o,
   output logic tx_done_o,
   output logic [15:0] tx_status_o,
   output logic rx_valid_o,
   output logic [15:0] rx_data_o,
   output logic rx_last_o,
   output logic rx_err_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] STATUS = 16'h0001;
   logic [15:0] got[$];
   logic [2:0] stall = 3'h5;
   // Idle values; status shows a changing pattern when not qualified by done.
   initial begin
      tx_ready_o = 1'b0;
      tx_done_o = 1'b0;
      tx_status_o = ~STATUS;
      rx_valid_o = 1'b0;
      rx_data_o = 16'h0000;
      rx_last_o = 1'b0;
      rx_err_o = 1'b0;
   end
   // Ready rotates so the transmitter must hold words through stalls.
   always @(posedge clk_i) begin
      stall <= {stall[1:0], stall[2]};
      tx_ready_o <= stall[0];
      tx_done_o <= 1'b0;
      tx_status_o <= ~tx_status_o;
      if (tx_valid_i && tx_ready_o) begin
         got.push_back(tx_data_i);
         if (tx_last_i) begin
            tx_done_o <= 1'b1;
            tx_status_o <= STATUS;
         end
      end
   end
   // Sends one frame; the data line then shows the inverse of its last word.
   task automatic send(input logic [15:0] w[$], input logic e);
      foreach (w[k]) begin
         @(posedge clk_i);
         rx_valid_o <= 1'b1;
         rx_data_o <= w[k];
         rx_last_o <= (k == w.size() - 1);
         rx_err_o <= e;
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_last_o <= 1'b0;
      rx_err_o <= 1'b0;
      rx_data_o <= ~w[w.size() - 1];
   endtask
endmodule

/* verification/mpb_buffer_host_tb.sv */
// Self-checking bench for the packet buffer host port.
module mpb_buffer_host_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [5:0] wb_adr_i = 6'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_we_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, tx_valid_o, tx_last_o, tx_ready_i, tx_crc_o, tx_done_i;
   logic rx_valid_i, rx_last_i, rx_err_i, full_duplex_o, phy_loopback_o;
   logic [15:0] tx_data_o, tx_status_i, rx_data_i, q;
   logic [15:0] w[$];
   logic [31:0] seed = 32'd35;
   int errors = 0;
   int n_tests = 0;
   int free_n = 4;
   ////////////////////////////////////////////////////////////////////////////
   always #10 clk_i = ~clk_i;
   mpb_buffer_host i_dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i,
      .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tx_valid_o, .tx_data_o, .tx_last_o,
      .tx_ready_i, .tx_crc_o, .tx_done_i, .tx_status_i, .rx_valid_i, .rx_data_i,
      .rx_last_i, .rx_err_i, .full_duplex_o, .phy_loopback_o);
   mpb_handler_model i_hdl (.clk_i, .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i), .tx_done_o(tx_done_i),
      .tx_status_o(tx_status_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
      .rx_last_o(rx_last_i), .rx_err_o(rx_err_i));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   task automatic test_done();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One classic cycle; the request holds until ack is sampled high.
   task automatic wb(input logic w, input logic [3:0] i, input logic [15:0] d);
      int k;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {i, 2'b00};
      wb_dat_i <= {16'h0000, d};
      wb_sel_i <= 4'h3;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (k >= 50) begin
         errors++;
         test_done();
      end
      q = wb_dat_o[15:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // Bank select first, so every access is independent of the last one.
   task automatic rg(input int b, input int w, input int i, input logic [15:0] d);
      wb(1'b1, 4'hE, {14'h0000, 2'(b)});
      wb(1'(w), 4'(i), d);
   endtask
   task automatic rd(input int b, input int i, input string nm, input logic [15:0] e);
      rg(b, 0, i, 16'h0000);
      chk(nm, q, e);
   endtask
   task automatic poll(input int i, input int bt, input logic v);
      int k;
      k = 0;
      do begin
         rg(2, 0, i, 16'h0000);
         k++;
      end while (q[bt] !== v && k < 300);
      chk("poll", 16'(q[bt]), 16'(v));
      if (k >= 300) test_done();
   endtask
   task automatic free_page(input int p);
      rg(2, 1, 2, 16'(p));
      rg(2, 1, 0, 16'h00A0);
      poll(0, 0, 1'b0);
      free_n++;
      rd(0, 8, "mir", {8'(free_n), 8'h04});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(0, 8, "mir", 16'h0404);
      rd(2, 4, "queue", 16'h8080);
      rd(1, 14, "bank", 16'h0001);
      // Fill memory; pages come out in order and the free count falls.
      for (int i = 0; i < 4; i++) begin
         rg(2, 1, 0, 16'h0020);
         poll(12, 3, 1'b1);
         free_n--;
         rd(2, 3, "page", 16'(i));
         rd(0, 8, "mir", {8'(free_n), 8'h04});
      end
      // A request with memory full must wait until a release.
      rg(2, 1, 0, 16'h0020);
      rg(2, 0, 3, 16'h0000);
      chk("pend", 16'(q[7]), 16'h0001);
      // The released page goes straight to the waiting request, so the count stays put.
      free_n--;
      free_page(2);
      poll(12, 3, 1'b1);
      rd(2, 3, "page", 16'h0002);
      free_page(3);
      // Random words through the data port with auto-advance, read back.
      w = {16'h0000, 16'h000A, rnd(), rnd(), rnd()};
      rg(2, 1, 2, 16'h0000);
      rg(2, 1, 6, 16'h4000);
      foreach (w[k]) rg(2, 1, 8, w[k]);
      rg(2, 1, 6, 16'h6000);
      foreach (w[k]) rd(2, 8, "data", w[k]);
      // Queued while disabled nothing leaves; enabling sends the frame.
      rg(2, 1, 0, 16'h00C0);
      repeat (20) @(posedge clk_i);
      chk("idle", 16'(i_hdl.got.size()), 16'h0000);
      rg(0, 1, 0, 16'h0001);
      chk("crc", 16'(tx_crc_o), 16'h0001);
      poll(12, 1, 1'b1);
      chk("txn", 16'(i_hdl.got.size()), 16'h0003);
      for (int k = 2; k < 5; k++) chk("tx", i_hdl.got[k - 2], w[k]);
      rg(2, 1, 6, 16'h6000);
      rd(2, 8, "stat", 16'h0001);
      rd(0, 2, "hst", 16'h0001);
      free_page(0);
      // A frame arriving while the receiver is off takes no memory.
      w = {rnd(), rnd(), rnd()};
      i_hdl.send(w, 1'b0);
      rd(0, 8, "mir", 16'h0204);
      rg(0, 1, 4, 16'h0100);
      i_hdl.send(w, 1'b0);
      poll(12, 0, 1'b1);
      rd(0, 8, "mir", 16'h0104);
      rg(2, 0, 4, 16'h0000);
      chk("rxq", 16'(q[15]), 16'h0000);
      rg(2, 1, 6, 16'hE000);
      rd(2, 8, "rst", 16'h0000);
      rd(2, 8, "rcnt", 16'h000A);
      foreach (w[k]) rd(2, 8, "rdat", w[k]);
      rg(2, 1, 0, 16'h0080);
      rd(0, 8, "mir", 16'h0204);
      // Mode bits reach their outputs; a memory reset frees every page and empties both queues.
      rg(0, 1, 0, 16'h0801);
      chk("fdx", 16'(full_duplex_o), 16'h0001);
      rg(3, 1, 2, 16'h4000);
      chk("plb", 16'(phy_loopback_o), 16'h0001);
      rg(2, 1, 0, 16'h0040);
      rd(0, 8, "mir", 16'h0404);
      rd(2, 4, "queue", 16'h8080);
      // Loopback with auto-release: the frame returns in a new page, its own page frees.
      rg(2, 1, 12, 16'h0002);
      rd(2, 12, "int", 16'h0000);
      rg(1, 1, 12, 16'h4800);
      rg(0, 1, 0, 16'h2001);
      rg(2, 1, 0, 16'h0020);
      poll(12, 3, 1'b1);
      rg(2, 1, 2, 16'h0000);
      rg(2, 1, 6, 16'h4000);
      w = {16'h0000, 16'h000A, rnd(), rnd(), rnd()};
      foreach (w[k]) rg(2, 1, 8, w[k]);
      rg(2, 1, 0, 16'h00C0);
      poll(12, 1, 1'b1);
      chk("wire", 16'(i_hdl.got.size()), 16'h0003);
      rd(0, 2, "hst", 16'h0000);
      rd(0, 8, "mir", 16'h0304);
      poll(12, 0, 1'b1);
      rg(2, 1, 6, 16'hE000);
      foreach (w[k]) rd(2, 8, "lbrx", w[k]);
      // Drop keeps the page; a transmit queue reset keeps its pages too.
      rg(2, 1, 0, 16'h0060);
      rd(0, 8, "mir", 16'h0304);
      rg(2, 0, 4, 16'h0000);
      chk("rxe", 16'(q[15]), 16'h0001);
      rg(0, 1, 0, 16'h0000);
      rg(2, 1, 2, 16'h0001);
      rg(2, 1, 0, 16'h00C0);
      rg(2, 0, 4, 16'h0000);
      chk("txq", 16'(q[7:0]), 16'h0001);
      rg(2, 1, 0, 16'h00E0);
      rg(2, 0, 4, 16'h0000);
      chk("txe", 16'(q[7]), 16'h0001);
      rd(0, 8, "mir", 16'h0304);
      // An errored frame is kept only while the keep bit is set.
      w = {rnd(), rnd(), rnd()};
      i_hdl.send(w, 1'b1);
      poll(12, 0, 1'b1);
      rd(0, 8, "mir", 16'h0204);
      rg(2, 1, 6, 16'hE000);
      rd(2, 8, "rerr", 16'h8000);
      rg(1, 1, 12, 16'h0800);
      i_hdl.send(w, 1'b1);
      repeat (10) @(posedge clk_i);
      rd(0, 8, "mir", 16'h0204);
      test_done();
   end
endmodule
